// File: shared/tuc_pkg.sv
package tuc_pkg;

    // ----------------------------------------------------------------
    // bus geometry and register offsets
    // ----------------------------------------------------------------
    localparam int TUC_AW = 4;
    localparam int TUC_DW = 16;
    localparam int TUC_PRE_W = 15;
    localparam logic [3:0] TUC_OFS_HALT = 4'h0;
    localparam logic [3:0] TUC_OFS_START = 4'h1;
    localparam logic [3:0] TUC_OFS_PRESCALE = 4'h2;
    localparam logic [3:0] TUC_OFS_MASK = 4'h3;
    localparam logic [3:0] TUC_OFS_REQUEST = 4'h4;
    localparam logic [3:0] TUC_OFS_MODE = 4'h5;
    localparam logic [3:0] TUC_OFS_RELOAD = 4'h6;
    localparam logic [3:0] TUC_OFS_CAPTURE = 4'h7;
    localparam logic [3:0] TUC_OFS_STATUS = 4'h8;
    localparam logic [3:0] TUC_OFS_COUNT = 4'h9;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int TUC_CH_N = 4;
    localparam int TUC_UH1_BIT = 9;
    localparam int TUC_UH3_BIT = 11;
    localparam int TUC_PRESCALE_FIELD_LSB = 0;
    localparam int TUC_PRS1_LSB = 4;
    localparam int TUC_PRS_W = 4;
    localparam int TUC_CKS_BIT = 15;
    localparam int TUC_CCS_BIT = 12;
    localparam int TUC_SPLIT_BIT = 11;
    localparam int TUC_STS_LSB = 8;
    localparam int TUC_CIS_LSB = 6;
    localparam int TUC_MD_LSB = 1;
    localparam int TUC_MD0_BIT = 0;
    localparam int TUC_IRQ_CH0_BIT = 6;
    localparam logic [15:0] TUC_MODE_WMASK = 16'h9FCF;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] TUC_RST_PRESCALE = 8'h00;
    localparam logic [7:0] TUC_RST_MASK = 8'hFF;
    localparam logic [7:0] TUC_RST_REQUEST = 8'h00;
    localparam logic [15:0] TUC_RST_MODE = 16'h0000;
    localparam logic [15:0] TUC_RST_WORD = 16'h0000;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] TUC_STS_SW = 3'h0;
    localparam logic [2:0] TUC_STS_EDGE = 3'h1;
    localparam logic [2:0] TUC_STS_BOTH = 3'h2;
    localparam logic [2:0] TUC_STS_MASTER = 3'h4;
    localparam logic [1:0] TUC_CIS_FALL = 2'h0;
    localparam logic [1:0] TUC_CIS_RISE = 2'h1;
    localparam logic [1:0] TUC_CIS_LOW_W = 2'h2;
    localparam logic [1:0] TUC_CIS_HIGH_W = 2'h3;
    localparam logic [2:0] TUC_MD_INTERVAL = 3'h0;
    localparam logic [2:0] TUC_MD_CAPTURE = 3'h2;
    localparam logic [2:0] TUC_MD_EVENT = 3'h3;
    localparam logic [2:0] TUC_MD_ONECOUNT = 3'h4;
    localparam logic [2:0] TUC_MD_CAPONE = 3'h6;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {TUC_CH_IDLE, TUC_CH_WAIT, TUC_CH_COUNT} tuc_ch_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } tuc_edge_t;

    typedef struct packed {
        logic [2:0] sync;
        tuc_edge_t edges;
    } tuc_edge_state_t;

    typedef struct packed {
        logic [7:0] prescale;
        logic [7:0] mask;
        logic [7:0] request;
        logic [15:0] mode;
        logic [3:0] run;
        logic [1:0] uh_run;
        logic [15:0] reload;
        logic [15:0] count;
        logic [15:0] capture;
        tuc_ch_t ch;
        logic [14:0] pre;
        logic [15:0] rdata;
        logic irq;
    } tuc_state_t;

endpackage : tuc_pkg

// File: hw/tuc_edge.sv
`timescale 1ns/100ps

module tuc_edge
    import tuc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic pin_in,
    output tuc_edge_t edges
);

    tuc_edge_state_t s;
    tuc_edge_state_t next_s;

    // ----------------------------------------------------------------
    // two-flop synchroniser, third flop only for edge history
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.sync = {s.sync[1:0], pin_in};
        next_s.edges.rise = s.sync[1] & ~s.sync[2];
        next_s.edges.fall = ~s.sync[1] & s.sync[2];
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign edges = s.edges;

endmodule : tuc_edge

// File: hw/tuc_top.sv
`timescale 1ns/100ps

// Functional notes
// - halt write of 1 clears channel running status and stops counting; 0 ignored.
// - halt bits 9 and 11 stop the upper 8-bit halves of channels 1 and 3.
// - prescale bits 3..0 divide the system clock by two to that power for clock one.
// - mask bit 0 lets the channel interrupt through; 1 blocks it.
// - channel event sets request flag and holds it; software writes 0 to clear.
// - mode bit 15 picks unit clock one (0) or two (1) as channel clock.
// - mode bit 12 counts channel clock (0) or valid input pin edges (1).
// - mode bit 11 runs the channel as one 16-bit timer (0) or one 8-bit timer in the low byte, upper byte held (1).
// - mode bits 10..8 choose software, valid edge, both edges or master start.
// - mode bits 7..6 pick falling, rising, or both edges for low/high width.
// - mode bits 3..1 pick interval, capture, event, one-count or capture one-count.
// - mode bit 0 gives start interrupt, or one-count retrigger with interrupt.

module tuc_top
    import tuc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [TUC_AW-1:0] reg_addr,
    input wire logic [TUC_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic timer_input_pin,
    input wire logic master_irq_pulse,
    output logic [TUC_DW-1:0] reg_rdata,
    output logic irq,
    output logic [TUC_CH_N-1:0] channel_running_status,
    output logic [1:0] upper_half_running
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // tick once every 2**sel cycles off the shared free-running divider
    function automatic logic div_tick(input logic [14:0] pre, input logic [3:0] sel);
        logic [15:0] m;
        m = (16'h0001 << sel) - 16'h0001;
        return &(pre | ~m[14:0]);
    endfunction : div_tick

    // terminal count sees only the low byte when the channel is split
    function automatic logic at_zero(input logic [15:0] v, input logic split);
        return split ? (v[7:0] == 8'h00) : (v == 16'h0000);
    endfunction : at_zero

    function automatic logic [15:0] step(input logic [15:0] v, input logic split,
                                         input logic up);
        logic [7:0] lo;
        lo = up ? v[7:0] + 8'h01 : v[7:0] - 8'h01;
        if (split)
        begin
            return {v[15:8], lo};
        end
        return up ? v + 16'h0001 : v - 16'h0001;
    endfunction : step

    tuc_state_t s;
    tuc_state_t next_s;
    tuc_edge_t pin_edges;

    // ----------------------------------------------------------------
    // input pin edge detection
    // ----------------------------------------------------------------
    tuc_edge u_edge (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin_in(timer_input_pin),
        .edges(pin_edges)
    );

    // ----------------------------------------------------------------
    // mode field decode
    // ----------------------------------------------------------------
    logic cks;
    logic ccs;
    logic split;
    logic [2:0] sts;
    logic [1:0] cis;
    logic [2:0] md;
    logic md0;
    logic up_mode;
    logic ck_one;
    logic ck_two;
    logic op_tick;
    logic valid_edge;
    logic count_tick;
    logic trig;
    logic start_ev;
    logic capt_ev;
    logic start_irq_ok;

    assign cks = s.mode[TUC_CKS_BIT];
    assign ccs = s.mode[TUC_CCS_BIT];
    assign split = s.mode[TUC_SPLIT_BIT];
    assign sts = s.mode[TUC_STS_LSB +: 3];
    assign cis = s.mode[TUC_CIS_LSB +: 2];
    assign md = s.mode[TUC_MD_LSB +: 3];
    assign md0 = s.mode[TUC_MD0_BIT];
    assign up_mode = (md == TUC_MD_CAPTURE) || (md == TUC_MD_CAPONE);
    // only interval and capture raise an interrupt at count start
    assign start_irq_ok = md0 && ((md == TUC_MD_INTERVAL) || (md == TUC_MD_CAPTURE));

    // ----------------------------------------------------------------
    // clock and trigger selection
    // ----------------------------------------------------------------
    always_comb
    begin
        ck_one = div_tick(s.pre, s.prescale[TUC_PRESCALE_FIELD_LSB +: TUC_PRS_W]);
        ck_two = div_tick(s.pre, s.prescale[TUC_PRS1_LSB +: TUC_PRS_W]);
        op_tick = cks ? ck_two : ck_one;
        case (cis)
            TUC_CIS_FALL: valid_edge = pin_edges.fall;
            TUC_CIS_RISE: valid_edge = pin_edges.rise;
            default: valid_edge = pin_edges.rise | pin_edges.fall;
        endcase
        count_tick = ccs ? valid_edge : op_tick;
        case (sts)
            TUC_STS_SW: trig = 1'b0;
            TUC_STS_EDGE: trig = valid_edge;
            TUC_STS_BOTH: trig = pin_edges.rise | pin_edges.fall;
            TUC_STS_MASTER: trig = master_irq_pulse;
            default: trig = 1'b0;
        endcase
        start_ev = trig;
        capt_ev = trig;
        // width measurement: for low/high width one edge opens the window, the other closes it; otherwise the valid edge does both
        if ((md == TUC_MD_CAPONE) && (sts != TUC_STS_SW))
        begin
            case (cis)
                TUC_CIS_LOW_W:
                begin
                    start_ev = pin_edges.fall;
                    capt_ev = pin_edges.rise;
                end
                TUC_CIS_HIGH_W:
                begin
                    start_ev = pin_edges.rise;
                    capt_ev = pin_edges.fall;
                end
                default:
                begin
                    start_ev = valid_edge;
                    capt_ev = valid_edge;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic wr_halt;
    logic wr_start;
    logic ev;
    logic [7:0] keep;

    always_comb
    begin
        next_s = s;
        ev = 1'b0;
        wr_halt = reg_wr && (reg_addr == TUC_OFS_HALT);
        wr_start = reg_wr && (reg_addr == TUC_OFS_START);
        next_s.pre = s.pre + 15'h0001;

        // plain register writes
        if (reg_wr)
        begin
            case (reg_addr)
                TUC_OFS_PRESCALE: next_s.prescale = reg_wdata[7:0];
                TUC_OFS_MASK: next_s.mask = reg_wdata[7:0];
                TUC_OFS_MODE: next_s.mode = reg_wdata & TUC_MODE_WMASK;
                TUC_OFS_RELOAD: next_s.reload = reg_wdata;
                default: next_s.mode = s.mode;
            endcase
        end

        // software start sets running status for every addressed channel
        if (wr_start)
        begin
            next_s.run = s.run | reg_wdata[TUC_CH_N-1:0];
            next_s.uh_run[0] = s.uh_run[0] | reg_wdata[TUC_UH1_BIT];
            next_s.uh_run[1] = s.uh_run[1] | reg_wdata[TUC_UH3_BIT];
        end

        // channel 0 counting engine
        case (s.ch)
            TUC_CH_IDLE:
            begin
                if (wr_start && reg_wdata[0])
                begin
                    if (sts == TUC_STS_SW)
                    begin
                        next_s.ch = TUC_CH_COUNT;
                        next_s.count = up_mode ? TUC_RST_WORD : s.reload;
                        ev = start_irq_ok;
                    end
                    else
                    begin
                        next_s.ch = TUC_CH_WAIT;
                    end
                end
            end
            TUC_CH_WAIT:
            begin
                if (start_ev)
                begin
                    next_s.ch = TUC_CH_COUNT;
                    next_s.count = up_mode ? TUC_RST_WORD : s.reload;
                    ev = start_irq_ok;
                end
            end
            TUC_CH_COUNT:
            begin
                if (up_mode)
                begin
                    if (capt_ev)
                    begin
                        next_s.capture = s.count;
                        next_s.count = TUC_RST_WORD;
                        ev = 1'b1;
                        if (md == TUC_MD_CAPONE)
                        begin
                            next_s.ch = TUC_CH_WAIT;
                        end
                    end
                    else if (count_tick)
                    begin
                        next_s.count = step(s.count, split, 1'b1);
                    end
                end
                else if ((md == TUC_MD_ONECOUNT) && md0 && start_ev)
                begin
                    // retrigger restarts the delay and reports it
                    next_s.count = s.reload;
                    ev = 1'b1;
                end
                else if (count_tick)
                begin
                    if (at_zero(s.count, split))
                    begin
                        ev = 1'b1;
                        if (md == TUC_MD_ONECOUNT)
                        begin
                            next_s.ch = TUC_CH_WAIT;
                        end
                        else
                        begin
                            next_s.count = s.reload;
                        end
                    end
                    else
                    begin
                        next_s.count = step(s.count, split, 1'b0);
                    end
                end
            end
            default: next_s.ch = TUC_CH_IDLE;
        endcase

        // halt overrides the channel state the engine chose this cycle; its count, capture and event still stand
        if (wr_halt)
        begin
            next_s.run = s.run & ~reg_wdata[TUC_CH_N-1:0];
            if (reg_wdata[TUC_UH1_BIT])
            begin
                next_s.uh_run[0] = 1'b0;
            end
            if (reg_wdata[TUC_UH3_BIT])
            begin
                next_s.uh_run[1] = 1'b0;
            end
            if (reg_wdata[0])
            begin
                next_s.ch = TUC_CH_IDLE;
            end
        end

        // request flags: a write of 0 clears, a same-cycle event still sets
        keep = (reg_wr && (reg_addr == TUC_OFS_REQUEST)) ? reg_wdata[7:0] : 8'hFF;
        next_s.request = s.request & keep;
        if (ev)
        begin
            next_s.request[TUC_IRQ_CH0_BIT] = 1'b1;
        end
        next_s.irq = |(next_s.request & ~next_s.mask);

        // read data stands only in the cycle after the strobe
        next_s.rdata = TUC_RST_WORD;
        if (reg_rd)
        begin
            case (reg_addr)
                TUC_OFS_HALT: next_s.rdata = TUC_RST_WORD;
                TUC_OFS_PRESCALE: next_s.rdata = {8'h00, s.prescale};
                TUC_OFS_MASK: next_s.rdata = {8'h00, s.mask};
                TUC_OFS_REQUEST: next_s.rdata = {8'h00, s.request};
                TUC_OFS_MODE: next_s.rdata = s.mode;
                TUC_OFS_RELOAD: next_s.rdata = s.reload;
                TUC_OFS_CAPTURE: next_s.rdata = s.capture;
                TUC_OFS_COUNT: next_s.rdata = s.count;
                TUC_OFS_STATUS:
                begin
                    next_s.rdata[TUC_CH_N-1:0] = s.run;
                    next_s.rdata[TUC_UH1_BIT] = s.uh_run[0];
                    next_s.rdata[TUC_UH3_BIT] = s.uh_run[1];
                end
                default: next_s.rdata = TUC_RST_WORD;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            s <= '0;
            s.prescale <= TUC_RST_PRESCALE;
            s.mask <= TUC_RST_MASK;
            s.request <= TUC_RST_REQUEST;
            s.mode <= TUC_RST_MODE;
            s.ch <= TUC_CH_IDLE;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign reg_rdata = s.rdata;
    assign irq = s.irq;
    assign channel_running_status = s.run;
    assign upper_half_running = s.uh_run;

endmodule : tuc_top

// File: sim/tuc_properties.sv
`timescale 1ns/100ps

module tuc_checker
    import tuc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [TUC_AW-1:0] reg_addr,
    input wire logic [TUC_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic timer_input_pin,
    input wire logic master_irq_pulse,
    input wire logic [TUC_DW-1:0] reg_rdata,
    input wire logic irq,
    input wire logic [TUC_CH_N-1:0] channel_running_status,
    input wire logic [1:0] upper_half_running
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic [15:0] wd_q;

    always_ff @(posedge core_clk)
    begin
        wd_q <= reg_wdata;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence wr_at(logic [3:0] a);
        reg_wr && reg_addr == a;
    endsequence

    sequence rd_at(logic [3:0] a);
        reg_rd && reg_addr == a;
    endsequence

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    chk_halt_clears:
    assert property (wr_at(TUC_OFS_HALT) |=> (channel_running_status & wd_q[3:0]) == 4'h0)
        else $error("halt write left a channel running");
    // channel 0 excluded, though its running bit, like the others, changes only on start and halt writes
    chk_halt_zero_keeps:
    assert property (wr_at(TUC_OFS_HALT) |=> ((channel_running_status
        ^ $past(channel_running_status)) & ~wd_q[3:0] & 4'hE) == 4'h0)
        else $error("halt write of zero changed a channel");
    chk_upper_halt:
    assert property (wr_at(TUC_OFS_HALT) |=>
        (upper_half_running & {wd_q[11], wd_q[9]}) == 2'b00)
        else $error("upper half still running after halt");
    chk_mask_blocks:
    assert property (wr_at(TUC_OFS_MASK) ##0 reg_wdata[7:0] == 8'hFF ##1 !reg_wr |=> !irq)
        else $error("irq high with all sources masked");
    chk_request_clear:
    assert property (wr_at(TUC_OFS_REQUEST) ##0 (reg_wdata[7:0] == 8'h00
        && !channel_running_status[0]) ##1 !reg_wr |=> !irq)
        else $error("irq high after request cleared");
    chk_irq_sticky:
    assert property (irq && !reg_wr && !$past(reg_wr) |=> irq)
        else $error("irq dropped without a register write");
    chk_rdata_idle:
    assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside read answer");
    chk_halt_reads_zero:
    assert property (rd_at(TUC_OFS_HALT) |=> reg_rdata == 16'h0000)
        else $error("halt register read back non zero");
    chk_mode_readback:
    assert property (wr_at(TUC_OFS_MODE) ##1 rd_at(TUC_OFS_MODE) |=>
        reg_rdata == ($past(reg_wdata, 2) & TUC_MODE_WMASK))
        else $error("mode register read back wrong");
    chk_prescale_back:
    assert property (wr_at(TUC_OFS_PRESCALE) ##1 rd_at(TUC_OFS_PRESCALE) |=>
        reg_rdata == ($past(reg_wdata, 2) & 16'h00FF))
        else $error("prescale register read back wrong");

endmodule : tuc_checker

bind tuc_top tuc_checker chk_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .timer_input_pin(timer_input_pin), .master_irq_pulse(master_irq_pulse),
    .reg_rdata(reg_rdata), .irq(irq), .channel_running_status(channel_running_status),
    .upper_half_running(upper_half_running)
);

// File: sim/tuc_top_bench.sv
`timescale 1ns/100ps

module tuc_top_bench
    import tuc_pkg::*;
;
    typedef struct {string what; logic [15:0] val;} tuc_note_t;

    logic core_clk;
    logic sys_rst;
    logic [TUC_AW-1:0] reg_addr;
    logic [TUC_DW-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic timer_input_pin;
    logic master_irq_pulse;
    logic [TUC_DW-1:0] reg_rdata;
    logic irq;
    logic [TUC_CH_N-1:0] channel_running_status;
    logic [1:0] upper_half_running;
    logic look;
    logic rd_d;
    int n_errors;
    int check_count;
    tuc_note_t notes[$];
    logic [2:0] md_codes [5] = '{TUC_MD_INTERVAL, TUC_MD_CAPTURE, TUC_MD_EVENT,
        TUC_MD_ONECOUNT, TUC_MD_CAPONE};
    logic [2:0] sts_codes [4] = '{TUC_STS_SW, TUC_STS_EDGE, TUC_STS_BOTH, TUC_STS_MASTER};

    tuc_top uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .timer_input_pin(timer_input_pin), .master_irq_pulse(master_irq_pulse),
        .reg_rdata(reg_rdata), .irq(irq), .channel_running_status(channel_running_status),
        .upper_half_running(upper_half_running)
    );

    always #50 core_clk = ~core_clk;

    // ----------------------------------------------------------------
    // drivers
    // ----------------------------------------------------------------
    // strobes are held into the next call, so calls run back to back
    task automatic bus(input logic w, input logic r, input logic l,
        input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= r;
        look <= l;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b1, 1'b0, 1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        notes.push_back('{"rdata", e});
        bus(1'b0, 1'b1, 1'b0, a, 16'h0000);
    endtask : rd

    // expected {irq, upper halves, running}
    task automatic lvl(input logic [6:0] e);
        notes.push_back('{"levels", {9'h000, e}});
        bus(1'b0, 1'b0, 1'b1, 4'h0, 16'h0000);
    endtask : lvl

    task automatic gap();
        bus(1'b0, 1'b0, 1'b0, 4'h0, 16'h0000);
    endtask : gap

    // ----------------------------------------------------------------
    // monitor
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic take(input logic [15:0] seen);
        tuc_note_t n;
        if (notes.size() == 0)
        begin
            n_errors++;
            $display("[ERR] result with no expectation seen %h", seen);
        end
        else
        begin
            n = notes.pop_front();
            check(n.what, seen, n.val);
        end
    endtask : take

    always @(posedge core_clk) rd_d <= reg_rd;

    always @(negedge core_clk)
    begin
        if (rd_d)
            take(reg_rdata);
        if (look)
            take({9'h000, irq, upper_half_running, channel_running_status});
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // pin levels hold 4 cycles each, one more than the 3-cycle sync path
    task automatic pin_pulses();
        repeat (2)
        begin
            repeat (4) @(posedge core_clk);
            timer_input_pin <= 1'b1;
            repeat (4) @(posedge core_clk);
            timer_input_pin <= 1'b0;
        end
        repeat (6) @(posedge core_clk);
    endtask : pin_pulses

    initial
    begin
        repeat (3000) @(posedge core_clk);
        n_errors++;
        $display("[ERR] watchdog expired");
        test_done();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        logic [31:0] r;
        logic [15:0] m;
        core_clk = 1'b0;
        sys_rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        look = 1'b0;
        timer_input_pin = 1'b0;
        master_irq_pulse = 1'b0;
        n_errors = 0;
        check_count = 0;
        void'($urandom(45));
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(TUC_OFS_PRESCALE, 16'h0000);
        rd(TUC_OFS_MASK, 16'h00FF);
        rd(TUC_OFS_REQUEST, 16'h0000);
        rd(TUC_OFS_MODE, 16'h0000);
        rd(TUC_OFS_HALT, 16'h0000);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'h0000);
        lvl(7'h00);
        gap();
        $display("test reset values done");
        for (int i = 0; i < 4; i++)
        begin
            r = $urandom;
            wr(TUC_OFS_PRESCALE, r[15:0]);
            rd(TUC_OFS_PRESCALE, {8'h00, r[7:0]});
        end
        gap();
        $display("test prescale done");
        for (int i = 0; i < 5; i++)
        begin
            r = $urandom;
            m = {r[0], 2'b00, r[1], r[2], sts_codes[i[1:0]], i[1:0], 2'b00, md_codes[i],
                r[3] & (i != 2) & (i != 4)};
            wr(TUC_OFS_MODE, m | 16'h6030);
            rd(TUC_OFS_MODE, m);
        end
        gap();
        $display("test mode fields done");
        wr(TUC_OFS_START, 16'h0A0F);
        lvl(7'h3F);
        wr(TUC_OFS_HALT, 16'h0000);
        lvl(7'h3F);
        wr(TUC_OFS_HALT, 16'h0001);
        lvl(7'h3E);
        wr(TUC_OFS_HALT, 16'h0200);
        lvl(7'h2E);
        wr(TUC_OFS_HALT, 16'h080E);
        rd(TUC_OFS_HALT, 16'h0000);
        lvl(7'h00);
        gap();
        $display("test halt done");
        wr(TUC_OFS_MODE, 16'h0144);
        wr(TUC_OFS_START, 16'h0001);
        gap();
        pin_pulses();
        rd(TUC_OFS_REQUEST, 16'h0040);
        lvl(7'h01);
        wr(TUC_OFS_MASK, 16'h00BF);
        gap();
        lvl(7'h41);
        wr(TUC_OFS_MASK, 16'h00FF);
        gap();
        lvl(7'h01);
        wr(TUC_OFS_MASK, 16'h00BF);
        wr(TUC_OFS_HALT, 16'h0001);
        gap();
        lvl(7'h40);
        wr(TUC_OFS_REQUEST, 16'h0000);
        gap();
        lvl(7'h00);
        wr(TUC_OFS_REQUEST, 16'h00FF);
        rd(TUC_OFS_REQUEST, 16'h0000);
        gap();
        repeat (3) @(posedge core_clk);
        $display("test interrupt done");
        // master start, interval with start interrupt, split, counting pin edges
        wr(TUC_OFS_RELOAD, 16'h0201);
        wr(TUC_OFS_MODE, 16'h1C41);
        wr(TUC_OFS_START, 16'h0001);
        gap();
        master_irq_pulse <= 1'b1;
        gap();
        master_irq_pulse <= 1'b0;
        rd(TUC_OFS_REQUEST, 16'h0040);
        wr(TUC_OFS_REQUEST, 16'h0000);
        gap();
        pin_pulses();
        // split: low byte hits zero on the second edge and reloads, a full word would not
        rd(TUC_OFS_COUNT, 16'h0201);
        rd(TUC_OFS_REQUEST, 16'h0040);
        wr(TUC_OFS_HALT, 16'h0001);
        gap();
        repeat (3) @(posedge core_clk);
        $display("test master start done");
        test_done();
    end

endmodule : tuc_top_bench
